// [rtl/tdmfe_cfg.svh]
// Purpose: constants of the TDM frame timing and input stream front end
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes: times in ns; derived tick counts are in master clock half periods, input run counts in full periods
`ifndef TDMFE_CFG_SVH
`define TDMFE_CFG_SVH

// timing
`define TDMFE_SYS_CLK_NS    25
`define TDMFE_MCLK_NS       122
`define TDMFE_TICK_NS       61
`define TDMFE_FP_NARROW_NS  122
`define TDMFE_FP_WIDE_NS    244
`define TDMFE_FP16_NAR_NS   61
`define TDMFE_FP16_WIDE_NS  122
`define TDMFE_IN_RUN_NAR    (`TDMFE_FP_NARROW_NS / `TDMFE_MCLK_NS)
`define TDMFE_IN_RUN_WIDE   (`TDMFE_FP_WIDE_NS / `TDMFE_MCLK_NS)
`define TDMFE_FP8_NAR_TK    (`TDMFE_FP_NARROW_NS / `TDMFE_TICK_NS)
`define TDMFE_FP8_WIDE_TK   (`TDMFE_FP_WIDE_NS / `TDMFE_TICK_NS)
`define TDMFE_FP16_NAR_TK   (`TDMFE_FP16_NAR_NS / `TDMFE_TICK_NS)
`define TDMFE_FP16_WIDE_TK  (`TDMFE_FP16_WIDE_NS / `TDMFE_TICK_NS)
`define TDMFE_IDLE_RUN      3'h7
`define TDMFE_RATE_32M      3'h4

// register offsets
`define TDMFE_ADR_CTRL      8'h00
`define TDMFE_ADR_BPRATE    8'h04
`define TDMFE_ADR_LCRATE    8'h08
`define TDMFE_ADR_STAT      8'h0c
`define TDMFE_ADR_DATA      8'h10

// control fields
`define TDMFE_CTRL_IN_EDGE  0
`define TDMFE_CTRL_OUT_EDGE 1
`define TDMFE_CTRL_FPW      2
`define TDMFE_CTRL_BP32     3
`define TDMFE_CTRL_LC32     4
`define TDMFE_CTRL_RST      5'h00
`define TDMFE_RATE_RST      32'h00000000

// status fields
`define TDMFE_STAT_GCI      16
`define TDMFE_STAT_LOCK     17
`endif

// [rtl/tdmfe_fifo.sv]
// Purpose: flip-flop FIFO between byte capture and the register port
// Assumes: DEPTH is a power of two
// Notes: ready drops when full, so the capture side holds its bytes
`default_nettype none
module tdmfe_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  input  wire logic clk_i,  // system clock
  input  wire logic rst_i,  // sync reset, high
  tdmfe_fifo_if.fifo q      // both handshakes
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp, next_wp, rp, next_rp;
  logic [AW:0]      cnt, next_cnt;
  logic             push, pop;

  // honest flags straight from the count
  assign q.wr_ready = (cnt != (AW+1)'(DEPTH));
  assign q.rd_valid = (cnt != '0);
  assign q.rd_data  = mem[rp];
  assign push       = q.wr_valid & q.wr_ready;
  assign pop        = q.rd_ready & q.rd_valid;

  // pointer and count update
  always_comb begin
    next_wp  = push ? wp + 1'b1 : wp;
    next_rp  = pop ? rp + 1'b1 : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
  end

  // storage is written only, never reset
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp] <= q.wr_data;
    end
  end

  a_fifo_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (push && !pop) |=> cnt == $past(cnt) + 1'b1)
    else $error("fifo count did not rise on push");
  a_fifo_full: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt == (AW+1)'(DEPTH)) |-> !push)
    else $error("fifo accepted a word while full");
endmodule // tdmfe_fifo
`default_nettype wire

// [rtl/tdmfe_fifo_if.sv]
// Purpose: valid/ready carrier between the capture logic and its FIFO
// Assumes: one clock domain
// Notes: write side and read side each handshake on valid and ready
`default_nettype none
interface tdmfe_fifo_if #(parameter int WIDTH = 22);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready,
                output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready,
                input wr_ready, rd_valid, rd_data);
endinterface // tdmfe_fifo_if
`default_nettype wire

// [rtl/tdmfe_pkg.sv]
// Purpose: types of the TDM frame timing front end
// Assumes: nothing beyond the cfg header
// Notes: the captured word is what the FIFO carries
`default_nettype none
package tdmfe_pkg;
  typedef enum logic [1:0] {
    ST_HUNT = 2'b01,
    ST_LOCK = 2'b10
  } tdmfe_lock_e;

  typedef struct packed {
    logic       loc_port;   // 0 backplane, 1 local
    logic [3:0] stream;
    logic [8:0] chan;
    logic [7:0] data;
  } tdmfe_word_s;

  typedef logic [2:0] tdmfe_rate_t;
endpackage
`default_nettype wire

// [rtl/tdmfe_top.sv]
// Purpose: frame timing and serial input stream front end of a TDM switch
// Assumes: every pin is synchronous to clk_i (40 MHz); the master clock
//   is sampled, so an edge is seen at most one clk_i cycle late
// Notes: each master half period gives two sample slots (the two clk_i
//   cycles after the edge), which sets the finest rate and the 16M clock
// Summary of operation
// - frame alignment follows the master clock edge chosen by in_edge.
// - an input pulse is one master period wide, or two when fpw is set.
// - the pulse style is found from the idle level without software.
// - the 8M clock has its out_edge-selected edge at the frame boundary.
// - the 8M frame pulse lasts 122 ns, or 244 ns when fpw is set.
// - output pulses repeat every frame and copy the detected style.
// - the 16M clock has its out_edge-selected edge at the frame boundary.
// - the 16M frame pulse lasts 61 ns, or 122 ns when fpw is set.
// - output launch strobes follow the generated clocks and frame.
// - below 32M a stream carries 256, 128, 64 or 32 channels a frame.
// - each input stream has its own rate field, free of the others.
// - in a port's 32M mode its streams 0 to 7 carry 512 channels.
// - in backplane 32M mode backplane streams 8 to 15 are ignored.
// - in local 32M mode local streams 8 to 15 are ignored.
`default_nettype none
`include "tdmfe_cfg.svh"
module tdmfe_top #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk_i,                       // system clock
  input  wire logic        rst_i,                       // sync reset
  input  wire logic [7:0]  adr_i,                       // byte address
  input  wire logic [31:0] dat_i,                       // write data
  output logic      [31:0] dat_o,                       // read data
  input  wire logic        we_i,                        // write
  input  wire logic [3:0]  sel_i,                       // byte lanes
  input  wire logic        stb_i,                       // strobe
  input  wire logic        cyc_i,                       // cycle
  output logic             ack_o,                       // acknowledge
  input  wire logic        master_clock_input_i,        // 8.192 MHz
  input  wire logic        frame_pulse_input_i,         // 8 kHz pulse
  input  wire logic [15:0] backplane_serial_inputs_i,   // streams
  input  wire logic [15:0] local_serial_inputs_i,       // streams
  output logic             output_clock_8m_o,           // 8M clock
  output logic             output_frame_pulse_8m_o,     // 8M pulse
  output logic             output_clock_16m_o,          // 16M clock
  output logic             output_frame_pulse_16m_o,    // 16M pulse
  output logic             frame_start_o,               // frame tick
  output logic             launch_strobe_o              // slot tick
);
  import tdmfe_pkg::*;

  // decode of a slot counter against a stream rate
  function automatic logic [11:0] slot_mask(input tdmfe_rate_t r);
    slot_mask = ~(12'hfff << (3'h4 - r));
  endfunction
  function automatic logic [11:0] bit_num(input logic [11:0] sl,
                                          input tdmfe_rate_t r);
    bit_num = sl >> (3'h4 - r);
  endfunction
  function automatic logic [4:0] first_set(input logic [31:0] v);
    first_set = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  // register state
  logic [4:0]  ctrl, next_ctrl;
  logic [31:0] bp_rate, next_bp_rate, lc_rate, next_lc_rate;
  logic [15:0] drop_cnt, next_drop_cnt;
  logic [31:0] next_dat;
  logic        next_ack, pop_rd;
  // timing state
  logic        mc_q, fp_samp, next_fp_samp, idle_level, next_idle;
  logic [2:0]  same_cnt, next_same;
  logic [1:0]  fp_run, next_run, need_run;
  logic [10:0] tick, next_tick;
  logic        ev_d1, ev_d2, boundary;
  tdmfe_lock_e state, next_state;
  // output state
  logic        next_clk8, next_clk16, next_fp8, next_fp16;
  logic        next_fstart, next_launch;
  logic [2:0]  w8, w16;
  // capture
  logic [31:0] all_in, pend_v, done_v, drop_v, take_v;
  logic [7:0]  hold_a [32];
  logic [8:0]  hch_a  [32];
  logic [4:0]  pick;
  logic        push_ok;
  tdmfe_word_s word;

  wire logic in_edge  = ctrl[`TDMFE_CTRL_IN_EDGE];
  wire logic out_edge = ctrl[`TDMFE_CTRL_OUT_EDGE];
  wire logic frame_pulse_width_select      = ctrl[`TDMFE_CTRL_FPW];
  wire logic bp32     = ctrl[`TDMFE_CTRL_BP32];
  wire logic lc32     = ctrl[`TDMFE_CTRL_LC32];
  wire logic ev0      = master_clock_input_i ^ mc_q;
  wire logic sel_edge = ev0 & (master_clock_input_i == in_edge);
  wire logic slot_ev  = ev_d1 | ev_d2;
  wire logic [11:0] slot = {tick, ev_d2};

  tdmfe_fifo_if #(.WIDTH($bits(tdmfe_word_s))) fq ();

  tdmfe_fifo #(.WIDTH($bits(tdmfe_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .q     (fq.fifo)
  );

  // frame alignment, style detection and slot count
  always_comb begin
    need_run     = frame_pulse_width_select ? 2'(`TDMFE_IN_RUN_WIDE) : 2'(`TDMFE_IN_RUN_NAR);
    next_fp_samp = fp_samp;
    next_idle    = idle_level;
    next_same    = same_cnt;
    next_run     = fp_run;
    next_state   = state;
    next_tick    = tick;
    boundary     = 1'b0;
    if (ev0) begin
      next_tick = tick + 11'h001;
    end
    if (sel_edge) begin
      next_fp_samp = frame_pulse_input_i;
      if (frame_pulse_input_i == fp_samp) begin
        if (same_cnt == `TDMFE_IDLE_RUN) begin
          next_idle = fp_samp;
        end else begin
          next_same = same_cnt + 3'h1;
        end
      end else begin
        next_same = 3'h0;
      end
      // a wide pulse is taken at its second sampled period
      if (frame_pulse_input_i != idle_level) begin
        next_run = (fp_run == 2'h3) ? fp_run : fp_run + 2'h1;
        if (fp_run + 2'h1 == need_run) begin
          boundary   = 1'b1;
          next_tick  = 11'h000;
          next_state = ST_LOCK;
        end
      end else begin
        next_run = 2'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mc_q       <= 1'b0;
      fp_samp    <= 1'b1;
      idle_level <= 1'b1;
      same_cnt   <= 3'h0;
      fp_run     <= 2'h0;
      tick       <= 11'h000;
      ev_d1      <= 1'b0;
      ev_d2      <= 1'b0;
      state      <= ST_HUNT;
    end else begin
      mc_q       <= master_clock_input_i;
      fp_samp    <= next_fp_samp;
      idle_level <= next_idle;
      same_cnt   <= next_same;
      fp_run     <= next_run;
      tick       <= next_tick;
      ev_d1      <= ev0;
      ev_d2      <= ev_d1;
      state      <= next_state;
    end
  end

  // generated clocks and pulses; the pulse is the idle level inverted
  always_comb begin
    w8  = frame_pulse_width_select ? 3'(`TDMFE_FP8_WIDE_TK) : 3'(`TDMFE_FP8_NAR_TK);
    w16 = frame_pulse_width_select ? 3'(`TDMFE_FP16_WIDE_TK) : 3'(`TDMFE_FP16_NAR_TK);
    next_clk8  = tick[0] ^ out_edge;
    next_clk16 = output_clock_16m_o;
    if (ev_d1) begin
      next_clk16 = out_edge;
    end else if (ev_d2) begin
      next_clk16 = ~out_edge;
    end
    next_fp8    = (tick < 11'(w8)) ? ~idle_level : idle_level;
    next_fp16   = (tick < 11'(w16)) ? ~idle_level : idle_level;
    next_fstart = ev_d1 & (tick == 11'h000);
    next_launch = slot_ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_clock_8m_o        <= 1'b0;
      output_clock_16m_o       <= 1'b0;
      output_frame_pulse_8m_o  <= 1'b1;
      output_frame_pulse_16m_o <= 1'b1;
      frame_start_o            <= 1'b0;
      launch_strobe_o          <= 1'b0;
    end else begin
      output_clock_8m_o        <= next_clk8;
      output_clock_16m_o       <= next_clk16;
      output_frame_pulse_8m_o  <= next_fp8;
      output_frame_pulse_16m_o <= next_fp16;
      frame_start_o            <= next_fstart;
      launch_strobe_o          <= next_launch;
    end
  end

  // per-stream deserialisers; data is taken as already aligned
  assign all_in = {local_serial_inputs_i, backplane_serial_inputs_i};
  for (genvar s = 0; s < 32; s++) begin : g_st
    localparam bit LOC  = (s >= 16);
    localparam bit HIGH = ((s % 16) >= 8);
    logic [7:0]  shf, next_shf, hold, next_hold;
    logic [8:0]  hch, next_hch;
    logic        pend, next_pend, done, off, is32;
    tdmfe_rate_t rate;
    logic [1:0]  rfield;
    logic [11:0] bn;

    assign is32   = LOC ? lc32 : bp32;
    assign rfield = LOC ? lc_rate[2*(s%16) +: 2] : bp_rate[2*(s%16) +: 2];
    assign rate   = is32 ? `TDMFE_RATE_32M : {1'b0, rfield};
    assign off    = is32 & HIGH;
    assign bn     = bit_num(slot, rate);

    always_comb begin
      next_shf  = shf;
      next_hold = hold;
      next_hch  = hch;
      next_pend = pend;
      done      = 1'b0;
      if (slot_ev && !off &&
          ((slot & slot_mask(rate)) == slot_mask(rate))) begin
        next_shf = {shf[6:0], all_in[s]};
        done     = (bn[2:0] == 3'h7);
      end
      // an ignored stream drops a byte held from before the mode change
      if (take_v[s] || off) begin
        next_pend = 1'b0;
      end
      // a fresh byte wins over the take of the held one
      if (done) begin
        next_hold = {shf[6:0], all_in[s]};
        next_hch  = bn[11:3];
        next_pend = 1'b1;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        shf  <= 8'h00;
        hold <= 8'h00;
        hch  <= 9'h000;
        pend <= 1'b0;
      end else begin
        shf  <= next_shf;
        hold <= next_hold;
        hch  <= next_hch;
        pend <= next_pend;
      end
    end

    assign pend_v[s] = pend & ~off;
    assign done_v[s] = done;
    assign drop_v[s] = done & pend & ~take_v[s];
    assign hold_a[s] = hold;
    assign hch_a[s]  = hch;
  end

  // lowest pending stream goes first; a full FIFO stalls the take
  always_comb begin
    pick          = first_set(pend_v);
    word.loc_port = pick[4];
    word.stream   = pick[3:0];
    word.chan     = hch_a[pick];
    word.data     = hold_a[pick];
    push_ok       = (pend_v != 32'h0) & fq.wr_ready;
    take_v        = push_ok ? (32'h1 << pick) : 32'h0;
  end
  assign fq.wr_valid = (pend_v != 32'h0);
  assign fq.wr_data  = word;
  assign fq.rd_ready = pop_rd;

  // classic Wishbone slave, one wait state, unmapped reads return zero
  always_comb begin
    next_ack      = cyc_i & stb_i & ~ack_o;
    next_dat      = 32'h0;
    next_ctrl     = ctrl;
    next_bp_rate  = bp_rate;
    next_lc_rate  = lc_rate;
    next_drop_cnt = drop_cnt;
    pop_rd        = 1'b0;
    if (next_ack && we_i) begin
      case (adr_i)
        `TDMFE_ADR_CTRL: begin
          if (sel_i[0]) begin
            next_ctrl = dat_i[4:0];
          end
        end
        `TDMFE_ADR_BPRATE, `TDMFE_ADR_LCRATE: begin
          for (int b = 0; b < 4; b++) begin
            if (sel_i[b] && adr_i == `TDMFE_ADR_BPRATE) begin
              next_bp_rate[8*b +: 8] = dat_i[8*b +: 8];
            end
            if (sel_i[b] && adr_i == `TDMFE_ADR_LCRATE) begin
              next_lc_rate[8*b +: 8] = dat_i[8*b +: 8];
            end
          end
        end
        `TDMFE_ADR_STAT: next_drop_cnt = 16'h0000;
        default: ;
      endcase
    end else if (next_ack) begin
      case (adr_i)
        `TDMFE_ADR_CTRL:   next_dat = {27'h0, ctrl};
        `TDMFE_ADR_BPRATE: next_dat = bp_rate;
        `TDMFE_ADR_LCRATE: next_dat = lc_rate;
        `TDMFE_ADR_STAT: begin
          next_dat[15:0]              = drop_cnt;
          next_dat[`TDMFE_STAT_GCI]  = ~idle_level;
          next_dat[`TDMFE_STAT_LOCK] = (state == ST_LOCK);
        end
        `TDMFE_ADR_DATA: begin
          next_dat = {fq.rd_valid, 9'h000, fq.rd_data};
          pop_rd   = fq.rd_valid;
        end
        default: ;
      endcase
    end
    // a lost byte counts even in the cycle of a clear
    if ((drop_v != 32'h0) && next_drop_cnt != 16'hffff) begin
      next_drop_cnt = next_drop_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o    <= 1'b0;
      dat_o    <= 32'h0;
      ctrl     <= `TDMFE_CTRL_RST;
      bp_rate  <= `TDMFE_RATE_RST;
      lc_rate  <= `TDMFE_RATE_RST;
      drop_cnt <= 16'h0000;
    end else begin
      ack_o    <= next_ack;
      dat_o    <= next_dat;
      ctrl     <= next_ctrl;
      bp_rate  <= next_bp_rate;
      lc_rate  <= next_lc_rate;
      drop_cnt <= next_drop_cnt;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_frame_align: assert property (boundary |=> tick == 11'h000 ##1
    (state == ST_LOCK)) else $error("boundary did not restart frame");
  a_wide_pulse: assert property ((sel_edge && frame_pulse_width_select && fp_run == 2'h0 &&
    frame_pulse_input_i != idle_level) |-> !boundary)
    else $error("wide pulse aligned on its first period");
  a_style_track: assert property ((sel_edge && same_cnt == 3'h7 &&
    frame_pulse_input_i == fp_samp) |=> idle_level == $past(fp_samp))
    else $error("idle level not learned");
  a_clk8_edge: assert property ((ev_d1 && tick == 11'h000) |=>
    output_clock_8m_o == $past(out_edge))
    else $error("8M clock edge not at frame boundary");
  a_fp8_width: assert property ((tick == 11'(w8)) |=>
    output_frame_pulse_8m_o == $past(idle_level))
    else $error("8M pulse too long");
  a_frame_wrap: assert property ((ev0 && tick == 11'h7ff && !boundary)
    |=> tick == 11'h000) else $error("frame did not wrap");
  a_clk16_edge: assert property ((ev_d1 && tick == 11'h000) |=>
    output_clock_16m_o == $past(out_edge) ##1
    output_clock_16m_o == ~$past(out_edge, 2))
    else $error("16M clock edge not at frame boundary");
  a_fp16_width: assert property ((tick == 11'h000 && !frame_pulse_width_select) |=>
    output_frame_pulse_16m_o == ~$past(idle_level))
    else $error("16M pulse missing at frame start");
  a_high_ignored: assert property (push_ok |-> !(pick[3] &&
    (pick[4] ? lc32 : bp32))) else $error("ignored stream captured");
endmodule // tdmfe_top
`default_nettype wire

// [test/tdmfe_far_end.sv]
// Purpose: far-end framer model: master clock, frame pulse, serial streams
// Assumes: HALF bench cycles per master half period, at least two
// Notes: the half period is coarser than the real one but keeps the edge
//   spacing the front end needs; 32M streams carry no modelled data
`default_nettype none
module tdmfe_far_end #(
  parameter int HALF = 3
) (
  input  wire logic        clk_i,    // bench clock
  input  wire logic        rst_i,    // sync reset, high
  input  wire logic        edge_i,   // boundary on rising edge when 1
  input  wire logic        wide_i,   // two-period frame pulse
  input  wire logic        gci_i,    // idle low pulse style
  input  wire logic [31:0] bprate_i, // backplane stream rates
  input  wire logic [31:0] lcrate_i, // local stream rates
  output logic             mclk_o,   // master clock
  output logic             fp_o,     // frame pulse
  output logic [15:0]      bp_o,     // backplane serial data
  output logic [15:0]      lc_o      // local serial data
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt;
  logic [10:0] h;
  logic [10:0] hn;
  logic [10:0] t;

  // byte carried by one channel, distinct per port, stream and channel
  function automatic logic [7:0] byte_of(input logic p, input logic [3:0] s,
                                         input logic [8:0] ch);
    return {s, 3'h0, p} ^ 8'(ch * 5 + 3);
  endfunction

  // serial bit in half period n at rate r, msb of each channel first
  function automatic logic bit_at(input logic p, input logic [3:0] s,
                                  input logic [1:0] r, input logic [10:0] n);
    logic [10:0] bi;
    logic [7:0]  b;
    bi = n >> (2'd3 - r);
    b  = byte_of(p, s, 9'(bi >> 3));
    return b[3'h7 - bi[2:0]];
  endfunction

  // a change of edge_i may swallow one edge but never makes a short one
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt    <= 0;
      h      <= 11'h000;
      mclk_o <= edge_i;
      fp_o   <= ~gci_i;
      bp_o   <= 16'h0000;
      lc_o   <= 16'h0000;
    end else if (cnt == HALF - 1) begin
      cnt    <= 0;
      hn     = h + 11'h001;
      h      <= hn;
      mclk_o <= edge_i ^ hn[0];
      t      = hn + (wide_i ? 11'h002 : 11'h001);
      fp_o   <= gci_i ^ ~(t < (wide_i ? 11'h004 : 11'h002));
      for (int s = 0; s < 16; s++) begin
        bp_o[s] <= bit_at(1'b0, 4'(s), bprate_i[2*s+:2], hn);
        lc_o[s] <= bit_at(1'b1, 4'(s), lcrate_i[2*s+:2], hn);
      end
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // tdmfe_far_end
`default_nettype wire

// [test/tdmfe_top_tb_top.sv]
// Purpose: self-checking bench of the TDM frame timing front end
// Assumes: far-end model runs HALF bench cycles per master half period
// Notes: FIFO entries left from a mode change are read and discarded
`default_nettype none
`include "tdmfe_cfg.svh"
module tdmfe_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF  = 3;
  localparam int FRAME = 2048 * HALF;
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] wd;
    logic [31:0] after;
  } tdmfe_row_s;
  localparam tdmfe_row_s ROWS [4] = '{
    '{`TDMFE_ADR_CTRL,   32'h0000001f, 32'h0000001f},
    '{`TDMFE_ADR_BPRATE, 32'hffffffff, 32'hffffffff},
    '{`TDMFE_ADR_LCRATE, 32'h12345678, 32'h12345678},
    '{8'h20,             32'hffffffff, 32'h00000000}};
  logic        clk_i, rst_i, we_i, stb_i, cyc_i, ack_o, mclk, fp;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o, bprate, lcrate, q;
  logic [3:0]  sel_i;
  logic [15:0] bp, lc;
  logic        ck8, fp8, ck16, fp16, fstart, lstrobe, edge_sel, wide, gci;
  int          n_errors, num_checks;

  tdmfe_top #(.FIFO_DEPTH(16)) tdmfe_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i),
    .cyc_i(cyc_i), .ack_o(ack_o), .master_clock_input_i(mclk),
    .frame_pulse_input_i(fp), .backplane_serial_inputs_i(bp),
    .local_serial_inputs_i(lc), .output_clock_8m_o(ck8),
    .output_frame_pulse_8m_o(fp8), .output_clock_16m_o(ck16),
    .output_frame_pulse_16m_o(fp16), .frame_start_o(fstart),
    .launch_strobe_o(lstrobe));

  tdmfe_far_end #(.HALF(HALF)) tdmfe_far_end_inst (
    .clk_i(clk_i), .rst_i(rst_i), .edge_i(edge_sel), .wide_i(wide),
    .gci_i(gci), .bprate_i(bprate), .lcrate_i(lcrate), .mclk_o(mclk),
    .fp_o(fp), .bp_o(bp), .lc_o(lc));

  // 40 MHz bench clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // classic single cycle; entered right after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int i;
    i = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1);
    r = dat_o;
    chk(32'(i), 32'd2);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // mode change, then two frames for the front end to settle again
  task automatic cfg(input logic [4:0] c, input logic g);
    wb(1'b1, `TDMFE_ADR_CTRL, {27'h0, c}, q);
    edge_sel <= c[0];
    wide     <= c[2];
    gci      <= g;
    repeat (2 * FRAME) @(posedge clk_i);
  endtask

  // one frame from a pulse onset: widths, period, strobes, clock edges
  task automatic measure(input logic pol, input logic ck, input int w8,
                         input int w16);
    int i, n8, n16, nf, nl;
    logic p8, p16;
    {i, n8, n16, nf, nl} = '0;
    // let a pulse already running pass, so that its onset is seen
    while (fp8 === pol && i < FRAME) begin
      @(posedge clk_i);
      i++;
    end
    {p8, p16} = {ck8, ck16};
    while (fp8 !== pol && i < 2 * FRAME) begin
      {p8, p16} = {ck8, ck16};
      @(posedge clk_i);
      i++;
    end
    chk({p8, ck8, p16, ck16}, {~ck, ck, ~ck, ck});
    for (i = 0; i < FRAME; i++) begin
      n8  += int'(fp8 === pol);
      n16 += int'(fp16 === pol);
      nf  += int'(fstart === 1'b1);
      nl  += int'(lstrobe === 1'b1);
      @(posedge clk_i);
    end
    chk(32'(fp8 === pol), 32'h1);
    chk(32'(n8), 32'(w8 * HALF));
    chk(32'(n16), 32'(w16 * HALF));
    chk(32'(nf), 32'h1);
    chk(32'(nl), 32'd4096);
  endtask

  // read captured words; stale ones from before the mode change dropped
  task automatic drain(input logic [1:0] m32);
    int nv;
    logic [1:0] r;
    nv = 0;
    for (int k = 0; k < 64; k++) begin
      wb(1'b0, `TDMFE_ADR_DATA, 32'h0, q);
      if (k >= 24 && q[31] === 1'b1) begin
        nv++;
        r = 2'((q[21] ? lcrate : bprate) >> (2 * q[20:17]));
        if (m32[q[21]] === 1'b1) chk(32'(q[20]), 32'h0);
        else begin
          chk(32'(q[7:0]), 32'(tdmfe_far_end_inst.byte_of(q[21],
              q[20:17], q[16:8])));
          chk(32'(q[16:8] < (10'd32 << r)), 32'h1);
        end
      end
    end
    chk(32'(nv > 0), 32'h1);
  endtask

  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {3'b100, 45'h0};
    {edge_sel, wide, gci, bprate, lcrate} = '0;
    {n_errors, num_checks} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({ack_o, ck8, ck16, fp8, fp16}, 5'b00011);
    // register reset values, write and read back, unmapped place
    foreach (ROWS[n]) begin
      wb(1'b0, ROWS[n].adr, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b1, ROWS[n].adr, ROWS[n].wd, q);
      wb(1'b0, ROWS[n].adr, 32'h0, q);
      chk(q, ROWS[n].after);
    end
    // every stream rate in use on both ports
    bprate <= 32'he4e4e4e4;
    lcrate <= 32'h1b1b1b1b;
    wb(1'b1, `TDMFE_ADR_BPRATE, 32'he4e4e4e4, q);
    wb(1'b1, `TDMFE_ADR_LCRATE, 32'h1b1b1b1b, q);
    // default mode, idle-high pulses
    cfg(5'h00, 1'b0);
    wb(1'b0, `TDMFE_ADR_STAT, 32'h0, q);
    chk(32'(q[17:16]), 32'h2);
    measure(1'b0, 1'b0, `TDMFE_FP8_NAR_TK, `TDMFE_FP16_NAR_TK);
    drain(2'b00);
    // rising input edge and wide pulses
    cfg(5'h05, 1'b0);
    measure(1'b0, 1'b0, `TDMFE_FP8_WIDE_TK, `TDMFE_FP16_WIDE_TK);
    drain(2'b00);
    // idle-low style, rising output edge, both ports at 32M
    cfg(5'h1a, 1'b1);
    wb(1'b0, `TDMFE_ADR_STAT, 32'h0, q);
    chk(32'(q[17:16]), 32'h3);
    measure(1'b1, 1'b1, `TDMFE_FP8_NAR_TK, `TDMFE_FP16_NAR_TK);
    drain(2'b11);
    summarize();
  end

  // three settled modes take about 75k cycles
  initial begin
    repeat (95000) @(posedge clk_i);
    n_errors++;
    summarize();
  end
endmodule // tdmfe_top_tb_top
`default_nettype wire
